// ---- verilog/ccpu_unit.sv ----
// Capture/compare/PWM channel with three period timers and AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_cfg.svh"
module ccpu_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] sixteen_bit_timer,
    input wire logic timer16_ext_clk,
    input wire logic sleep,
    input wire logic capture_in,
    output logic timer16_clear,
    output logic timer16_hold,
    output logic adc_trigger,
    output logic wake_req,
    output logic channel_pin,
    output logic channel_out
);
    // ****************************************
    // Helpers
    // ****************************************
    // Last prescaler count before the timer steps
    function automatic logic [6:0] ps_max(input logic [2:0] ps);
        logic [7:0] one;
        one = 8'h01 << ps;
        return 7'(one - 8'h01);
    endfunction
    // Two low time-base bits: clock phase at 1:1, prescaler bit 0 and phase bit 1 at 1:2, prescaler bits otherwise
    function automatic logic [1:0] tb_low(input logic [2:0] ps, input logic [6:0] pc,
                                          input logic [1:0] ph);
        logic [8:0] full;
        full = {pc, ph} >> ps;
        return full[1:0];
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic aw_have, w_have, ctl_en, ctl_fmt, ev_flag, adc_sel, wake_en;
    logic out_q, match_d, pend_clr, pulse_on, cap_s1, cap_s2, cap_s3;
    logic [7:0] aw_addr, w_data, val_lo, val_hi;
    logic [3:0] ctl_mode, cap_cnt;
    logic [1:0] tsel, phase;
    logic [2:0] tm_flag, ton;
    logic [9:0] duty_buf;
    logic [7:0] pr [0:2];
    logic [7:0] tmr [0:2];
    logic [6:0] pcnt [0:2];
    logic [2:0] tps [0:2];
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic next_aw_have, next_w_have, next_ctl_en, next_ctl_fmt, next_ev_flag;
    logic next_adc_sel, next_wake_en, next_out_q, next_match_d, next_pend_clr;
    logic next_pulse_on, next_t16_clear, next_t16_hold, next_adc_trig, next_wake;
    logic [7:0] next_aw_addr, next_w_data, next_val_lo, next_val_hi;
    logic [3:0] next_ctl_mode, next_cap_cnt;
    logic [1:0] next_tsel, next_phase;
    logic [2:0] next_tm_flag, next_ton;
    logic [9:0] next_duty_buf;
    logic [7:0] next_pr [0:2];
    logic [7:0] next_tmr [0:2];
    logic [6:0] next_pcnt [0:2];
    logic [2:0] next_tps [0:2];

    // Capture pin synchroniser; first stage feeds only the second
    always_ff @(posedge aclk) begin
        cap_s1 <= capture_in;
        cap_s2 <= cap_s1;
        cap_s3 <= cap_s2;
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic tick, run, wr, rd, hit_sel, step, match, evt, cap_evt, rise, fall;
        logic [2:0] hit, wclr;
        logic [7:0] wa, ra;
        logic [1:0] ridx, widx;
        logic [9:0] duty_new, tbase;
        logic [15:0] value;
        ccpu_pkg::ccpu_mode_t mode;
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_aw_have = aw_have;
        next_w_have = w_have;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_ctl_en = ctl_en;
        next_ctl_fmt = ctl_fmt;
        next_ctl_mode = ctl_mode;
        next_val_lo = val_lo;
        next_val_hi = val_hi;
        next_tsel = tsel;
        next_adc_sel = adc_sel;
        next_wake_en = wake_en;
        next_ton = ton;
        next_pr = pr;
        next_tps = tps;
        next_tmr = tmr;
        next_pcnt = pcnt;
        next_duty_buf = duty_buf;
        next_out_q = out_q;
        next_pulse_on = 1'b0;
        next_cap_cnt = cap_cnt;
        next_pend_clr = 1'b0;
        hit = 3'h0;
        wclr = 3'h0;
        evt = 1'b0;
        cap_evt = 1'b0;
        mode = ccpu_pkg::ccpu_mode_t'(ctl_mode);
        value = {val_hi, val_lo};
        // Sixteen-bit timer is told to hold in sleep unless externally clocked
        next_t16_hold = sleep & ~timer16_ext_clk;
        run = ~sleep | timer16_ext_clk;
        // Instruction-clock phase; the period timers stop in sleep
        next_phase = phase + 2'h1;
        tick = (phase == `CCPU_QMAX) & ~sleep;
        for (int i = 0; i < `CCPU_NTIMERS; i++) begin
            step = ton[i] & tick & (pcnt[i] == ps_max(tps[i]));
            if (ton[i] && tick) begin
                next_pcnt[i] = step ? 7'h00 : 7'(pcnt[i] + 7'h01);
            end
            // Period match clears the timer on the next step, no postscaler
            if (step && tmr[i] == pr[i]) begin
                hit[i] = 1'b1;
                next_tmr[i] = 8'h00;
            end else if (step) begin
                next_tmr[i] = 8'(tmr[i] + 8'h01);
            end
        end
        // ---- AXI4-Lite address and data capture ----
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_have = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_have = 1'b1;
            next_w_data = s_axi_wstrb[0] ? s_axi_wdata[7:0] : w_data;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        wr = aw_have & w_have & ~s_axi_bvalid;
        wa = aw_addr;
        widx = wa[3:2];
        if (wr) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `CCPU_RESP_OK;
            if (wa == `CCPU_OFF_CTRL) begin
                next_ctl_en = w_data[`CCPU_CTRL_EN];
                next_ctl_fmt = w_data[`CCPU_CTRL_FMT];
                next_ctl_mode = w_data[3:0];
                if (w_data == `CCPU_RST_BYTE) begin
                    next_out_q = 1'b0;
                end
            end else if (wa == `CCPU_OFF_VLO) begin
                next_val_lo = w_data;
            end else if (wa == `CCPU_OFF_VHI) begin
                next_val_hi = w_data;
            end else if (wa == `CCPU_OFF_TSEL) begin
                next_tsel = (w_data[1:0] == 2'h3) ? 2'h0 : w_data[1:0];
            end else if (wa == `CCPU_OFF_STAT) begin
                wclr = w_data[3:1];
            end else if (wa == `CCPU_OFF_CFG) begin
                next_adc_sel = w_data[`CCPU_CFG_ADC];
                next_wake_en = w_data[`CCPU_CFG_WAKE];
            end else if (wa[7:4] == `CCPU_OFF_PR && widx != 2'h3) begin
                next_pr[widx] = w_data;
            end else if (wa[7:4] == `CCPU_OFF_TCON && widx != 2'h3) begin
                next_ton[widx] = w_data[`CCPU_TCON_ON];
                next_tps[widx] = w_data[`CCPU_TCON_PS +: 3];
            end else if (wa[7:4] == `CCPU_OFF_TCNT && widx != 2'h3) begin
                next_tmr[widx] = w_data;
            end else begin
                next_bresp = `CCPU_RESP_ERR;
            end
        end
        next_awready = ~next_aw_have;
        next_wready = ~next_w_have;
        // ---- AXI4-Lite read ----
        rd = s_axi_arvalid & s_axi_arready;
        ra = s_axi_araddr;
        ridx = ra[3:2];
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (rd) begin
            next_rvalid = 1'b1;
            next_arready = 1'b0;
            next_rresp = `CCPU_RESP_OK;
            next_rdata = 32'h0000_0000;
            if (ra == `CCPU_OFF_CTRL) begin
                next_rdata[7:0] = {ctl_en, 1'b0, out_q, ctl_fmt, ctl_mode};
            end else if (ra == `CCPU_OFF_VLO) begin
                next_rdata[7:0] = val_lo;
            end else if (ra == `CCPU_OFF_VHI) begin
                next_rdata[7:0] = val_hi;
            end else if (ra == `CCPU_OFF_TSEL) begin
                next_rdata[1:0] = tsel;
            end else if (ra == `CCPU_OFF_STAT) begin
                next_rdata[3:0] = {tm_flag, ev_flag};
            end else if (ra == `CCPU_OFF_CFG) begin
                next_rdata[1:0] = {wake_en, adc_sel};
            end else if (ra[7:4] == `CCPU_OFF_PR && ridx != 2'h3) begin
                next_rdata[7:0] = pr[ridx];
            end else if (ra[7:4] == `CCPU_OFF_TCON && ridx != 2'h3) begin
                next_rdata[7:0] = {ton[ridx], tps[ridx], 4'h0};
            end else if (ra[7:4] == `CCPU_OFF_TCNT && ridx != 2'h3) begin
                next_rdata[7:0] = tmr[ridx];
            end else begin
                next_rresp = `CCPU_RESP_ERR;
            end
        end
        // ---- Channel modes ----
        match = ctl_en & run & (value == sixteen_bit_timer);
        rise = cap_s2 & ~cap_s3;
        fall = ~cap_s2 & cap_s3;
        hit_sel = hit[tsel];
        // Time base after this edge, so the pin falls as the count reaches the duty
        tbase = {next_tmr[tsel], tb_low(tps[tsel], next_pcnt[tsel], next_phase)};
        duty_new = ctl_fmt ? {val_hi, val_lo[7:6]} : {val_hi[1:0], val_lo};
        if (pulse_on) begin
            next_out_q = 1'b0;
        end
        unique case (mode)
            ccpu_pkg::CCPU_OFF: begin
                next_out_q = 1'b0;
                next_cap_cnt = 4'h0;
                match = 1'b0;
            end
            ccpu_pkg::CCPU_CMP_SET, ccpu_pkg::CCPU_CMP_CLR, ccpu_pkg::CCPU_CMP_TOG,
            ccpu_pkg::CCPU_CMP_TOG_CLR, ccpu_pkg::CCPU_CMP_PULSE,
            ccpu_pkg::CCPU_CMP_PULSE_CLR: begin
                next_cap_cnt = 4'h0;
                evt = match & ~match_d;
                if (evt) begin
                    unique case (mode)
                        ccpu_pkg::CCPU_CMP_SET: next_out_q = 1'b1;
                        ccpu_pkg::CCPU_CMP_CLR: next_out_q = 1'b0;
                        ccpu_pkg::CCPU_CMP_TOG, ccpu_pkg::CCPU_CMP_TOG_CLR: begin
                            next_out_q = ~out_q;
                        end
                        default: begin
                            next_out_q = 1'b1;
                            next_pulse_on = 1'b1;
                        end
                    endcase
                    next_pend_clr = (mode == ccpu_pkg::CCPU_CMP_TOG_CLR) |
                                    (mode == ccpu_pkg::CCPU_CMP_PULSE_CLR);
                end
            end
            ccpu_pkg::CCPU_CAP_ANY, ccpu_pkg::CCPU_CAP_FALL, ccpu_pkg::CCPU_CAP_RISE,
            ccpu_pkg::CCPU_CAP_RISE4, ccpu_pkg::CCPU_CAP_RISE16: begin
                match = 1'b0;
                if (ctl_en && run) begin
                    if (mode == ccpu_pkg::CCPU_CAP_ANY) begin
                        cap_evt = rise | fall;
                    end else if (mode == ccpu_pkg::CCPU_CAP_FALL) begin
                        cap_evt = fall;
                    end else if (mode == ccpu_pkg::CCPU_CAP_RISE) begin
                        cap_evt = rise;
                    end else if (rise) begin
                        next_cap_cnt = 4'(cap_cnt + 4'h1);
                        cap_evt = (mode == ccpu_pkg::CCPU_CAP_RISE4) ?
                                  (cap_cnt[1:0] == 2'h3) : (cap_cnt == 4'hf);
                    end
                end
                evt = cap_evt;
            end
            ccpu_pkg::CCPU_PWM: begin
                next_cap_cnt = 4'h0;
                match = 1'b0;
                if (ctl_en && hit_sel) begin
                    next_duty_buf = duty_new;
                    next_out_q = (duty_new != 10'h000);
                end else if (ctl_en && ton[tsel] && !sleep && tbase == duty_buf) begin
                    next_out_q = 1'b0;
                end
            end
            default: begin
                next_cap_cnt = 4'h0;
                match = 1'b0;
            end
        endcase
        // Capture stores the count over any software write of the pair
        if (cap_evt) begin
            next_val_hi = sixteen_bit_timer[15:8];
            next_val_lo = sixteen_bit_timer[7:0];
        end
        next_match_d = match;
        // Timer reset only if the match still stands one edge later
        next_t16_clear = pend_clr & ctl_en & (value == sixteen_bit_timer);
        next_adc_trig = evt & adc_sel;
        next_wake = evt & wake_en & sleep;
        // Sticky flags; a set in the clearing cycle wins
        next_ev_flag = ev_flag | evt;
        if (wr && wa == `CCPU_OFF_STAT && w_data[0] && !evt) begin
            next_ev_flag = 1'b0;
        end
        next_tm_flag = (tm_flag & ~wclr) | hit;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCPU_RESP_OK;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `CCPU_RESP_OK;
            s_axi_rdata <= 32'h0000_0000;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= `CCPU_RST_BYTE;
            w_data <= `CCPU_RST_BYTE;
            ctl_en <= 1'b0;
            ctl_fmt <= 1'b0;
            ctl_mode <= 4'h0;
            val_lo <= `CCPU_RST_BYTE;
            val_hi <= `CCPU_RST_BYTE;
            tsel <= 2'h0;
            adc_sel <= 1'b0;
            wake_en <= 1'b0;
            ev_flag <= 1'b0;
            tm_flag <= 3'h0;
            ton <= 3'h0;
            phase <= 2'h0;
            duty_buf <= 10'h000;
            out_q <= 1'b0;
            match_d <= 1'b0;
            pend_clr <= 1'b0;
            pulse_on <= 1'b0;
            cap_cnt <= 4'h0;
            timer16_clear <= 1'b0;
            timer16_hold <= 1'b0;
            adc_trigger <= 1'b0;
            wake_req <= 1'b0;
            channel_pin <= 1'b0;
            channel_out <= 1'b0;
            for (int i = 0; i < `CCPU_NTIMERS; i++) begin
                pr[i] <= `CCPU_RST_PR;
                tps[i] <= 3'h0;
                tmr[i] <= `CCPU_RST_BYTE;
                pcnt[i] <= 7'h00;
            end
        end else begin
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            ctl_en <= next_ctl_en;
            ctl_fmt <= next_ctl_fmt;
            ctl_mode <= next_ctl_mode;
            val_lo <= next_val_lo;
            val_hi <= next_val_hi;
            tsel <= next_tsel;
            adc_sel <= next_adc_sel;
            wake_en <= next_wake_en;
            ev_flag <= next_ev_flag;
            tm_flag <= next_tm_flag;
            ton <= next_ton;
            phase <= next_phase;
            duty_buf <= next_duty_buf;
            out_q <= next_out_q;
            match_d <= next_match_d;
            pend_clr <= next_pend_clr;
            pulse_on <= next_pulse_on;
            cap_cnt <= next_cap_cnt;
            timer16_clear <= next_t16_clear;
            timer16_hold <= next_t16_hold;
            adc_trigger <= next_adc_trig;
            wake_req <= next_wake;
            channel_pin <= next_out_q;
            channel_out <= next_out_q;
            pr <= next_pr;
            tps <= next_tps;
            tmr <= next_tmr;
            pcnt <= next_pcnt;
        end
    end
endmodule
`default_nettype wire

// ---- include/ccpu_cfg.svh ----
// Register offsets, field positions and reset values of the channel
`ifndef CCPU_CFG_SVH
`define CCPU_CFG_SVH
`define CCPU_ADDR_W 8
`define CCPU_OFF_CTRL 8'h00
`define CCPU_OFF_VLO 8'h04
`define CCPU_OFF_VHI 8'h08
`define CCPU_OFF_TSEL 8'h0c
`define CCPU_OFF_STAT 8'h10
`define CCPU_OFF_CFG 8'h14
`define CCPU_OFF_PR 4'h2
`define CCPU_OFF_TCON 4'h3
`define CCPU_OFF_TCNT 4'h4
`define CCPU_CTRL_EN 7
`define CCPU_CTRL_OUT 5
`define CCPU_CTRL_FMT 4
`define CCPU_TCON_ON 7
`define CCPU_TCON_PS 4
`define CCPU_CFG_ADC 0
`define CCPU_CFG_WAKE 1
`define CCPU_RST_BYTE 8'h00
`define CCPU_RST_PR 8'hff
`define CCPU_NTIMERS 3
`define CCPU_QMAX 2'h3
`define CCPU_RESP_OK 2'h0
`define CCPU_RESP_ERR 2'h2
`endif

// ---- include/ccpu_pkg.sv ----
// Types shared by the capture/compare/PWM channel
package ccpu_pkg;
    typedef enum logic [3:0] {
        CCPU_OFF = 4'h0,
        CCPU_CMP_TOG_CLR = 4'h1,
        CCPU_CMP_TOG = 4'h2,
        CCPU_CAP_ANY = 4'h3,
        CCPU_CAP_FALL = 4'h4,
        CCPU_CAP_RISE = 4'h5,
        CCPU_CAP_RISE4 = 4'h6,
        CCPU_CAP_RISE16 = 4'h7,
        CCPU_CMP_SET = 4'h8,
        CCPU_CMP_CLR = 4'h9,
        CCPU_CMP_PULSE = 4'ha,
        CCPU_CMP_PULSE_CLR = 4'hb,
        CCPU_PWM = 4'hf
    } ccpu_mode_t;
endpackage

// ---- testbench/ccpu_timer_model.sv ----
// Model of the shared sixteen-bit timer
`timescale 1ns/1ps
`default_nettype none
module ccpu_timer_model #(
    parameter logic [15:0] WRAP = 16'h003f
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic hold,
    output logic [15:0] count
);
    // ***
    // Timer
    // ***
    logic [1:0] ph;
    // Steps once every four clocks, stops while held
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            count <= 16'h0000;
            ph <= 2'h0;
        end else if (!hold) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) count <= (count == WRAP) ? 16'h0000 : count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/ccpu_unit_props.sv ----
// Checker of bus answers and channel outputs
`timescale 1ns/1ps
`default_nettype none
module ccpu_unit_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep,
    input wire logic timer16_ext_clk,
    input wire logic timer16_hold,
    input wire logic timer16_clear,
    input wire logic adc_trigger,
    input wire logic channel_pin,
    input wire logic channel_out
);
    // ***
    // Properties
    // ***
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wlat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:1] s_axi_rvalid;
    endproperty
    property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    property p_mirror; channel_out == channel_pin; endproperty
    property p_hold; timer16_hold == ($past(sleep) && !$past(timer16_ext_clk)); endproperty
    property p_trig; adc_trigger |=> !adc_trigger; endproperty
    property p_clr; timer16_clear |-> $past(adc_trigger) && !$past(timer16_clear); endproperty
    a_wlat: assert property (p_wlat) else $error("write answer missing");
    a_rlat: assert property (p_rlat) else $error("read answer missing");
    a_bdone: assert property (p_bdone) else $error("write answer repeated");
    a_rdone: assert property (p_rdone) else $error("read answer repeated");
    a_mirror: assert property (p_mirror) else $error("outputs differ");
    a_hold: assert property (p_hold) else $error("hold wrong");
    a_trig: assert property (p_trig) else $error("trigger too long");
    a_clr: assert property (p_clr) else $error("clear without trigger");
    c_trig: cover property (adc_trigger);
    c_clr: cover property (timer16_clear);
    c_pwm: cover property ($rose(channel_pin));
endmodule
bind ccpu_unit ccpu_unit_props u_props (.*);
`default_nettype wire

// ---- testbench/ccpu_unit_tb.sv ----
// Testbench of the capture/compare/PWM channel
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ccpu_unit_tb;
    logic aclk = 1'b0, aresetn = 1'b0, sleep = 1'b0, cap = 1'b0, ext = 1'b0, v;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic timer16_clear, timer16_hold, adc_trigger, wake_req, channel_pin, channel_out;
    logic [15:0] sixteen_bit_timer;
    logic [3:0] md [6] = '{4'h8, 4'h9, 4'h2, 4'h1, 4'ha, 4'hb};
    logic ex [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    int errors = 0, checks_done = 0, trig_n = 0, clr_n = 0, wake_n = 0, h, p, n;
    ccpu_unit uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sixteen_bit_timer, .timer16_ext_clk(ext), .sleep, .capture_in(cap),
        .timer16_clear, .timer16_hold, .adc_trigger, .wake_req, .channel_pin, .channel_out
    );
    ccpu_timer_model tmr (.aclk, .aresetn, .clear(timer16_clear), .hold(timer16_hold),
        .count(sixteen_bit_timer));
    // ***
    // Clock, counters and tasks
    // ***
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (adc_trigger === 1'b1) trig_n++;
        if (timer16_clear === 1'b1) clr_n++;
        if (wake_req === 1'b1) wake_n++;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One bus transfer; handshakes are judged from mid-cycle values
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, td, tk, tr, rv;
        int k;
        k = 0;
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            td = s_axi_wvalid && s_axi_wready;
            tk = s_axi_bvalid && s_axi_bready;
            tr = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid && s_axi_rready;
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (td) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            if (tk) s_axi_bready <= 1'b0;
            if (rv) s_axi_rready <= 1'b0;
            k++;
        end while (!(tk || rv) && k < 50);
        if (!(tk || rv)) begin errors++; wrap_up(); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h000000, d});
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h00000000);
    endtask
    task automatic wait_pin(input logic lv);
        int k;
        k = 0;
        do begin @(negedge aclk); k++; end while (channel_pin !== lv && k < 2000);
        if (channel_pin !== lv) begin errors++; wrap_up(); end
    endtask
    // High time and period of the next whole pulse
    task automatic meas;
        h = 0;
        wait_pin(1'b0);
        wait_pin(1'b1);
        while (channel_pin === 1'b1 && h < 3000) begin @(negedge aclk); h++; end
        p = h;
        while (channel_pin === 1'b0 && p < 3000) begin @(negedge aclk); p++; end
    endtask
    initial begin
        repeat (100000) @(posedge aclk);
        errors++;
        wrap_up();
    end
    // ***
    // Tests
    // ***
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h20); `CHK(q[7:0], `CCPU_RST_PR)
        rd(8'hfc); `CHK(r, `CCPU_RESP_ERR)
        $display("test reset done");
        wr(`CCPU_OFF_VLO, 8'h10);
        wr(`CCPU_OFF_VHI, 8'h00);
        wr(`CCPU_OFF_CFG, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(`CCPU_OFF_CTRL, 8'h00);
            rd(`CCPU_OFF_CTRL); `CHK(q[5], 1'b0)
            wr(`CCPU_OFF_STAT, 8'h01);
            wr(`CCPU_OFF_CTRL, {4'h8, md[i]});
            n = 0;
            do begin rd(`CCPU_OFF_STAT); n++; end while (q[0] !== 1'b1 && n < 200);
            rd(`CCPU_OFF_CTRL); `CHK(q[5], ex[i])
        end
        `CHK(trig_n, 6)
        `CHK(clr_n, 2)
        $display("test compare done");
        wr(`CCPU_OFF_CTRL, 8'h00);
        wr(8'h20, 8'h03);
        wr(`CCPU_OFF_TSEL, 8'h00);
        wr(`CCPU_OFF_CTRL, 8'h8f);
        wr(`CCPU_OFF_VLO, 8'h06);
        wr(`CCPU_OFF_VHI, 8'h00);
        wr(`CCPU_OFF_STAT, 8'h0e);
        wr(8'h30, 8'h80);
        n = 0;
        do begin rd(`CCPU_OFF_STAT); n++; end while (q[1] !== 1'b1 && n < 50);
        `CHK(q[1], 1'b1)
        meas(); `CHK(h, 6)
        `CHK(p, 16)
        wait_pin(1'b0);
        wr(`CCPU_OFF_CTRL, 8'h9f);
        wr(`CCPU_OFF_VHI, 8'h02);
        wr(`CCPU_OFF_VLO, 8'h40);
        meas(); `CHK(h, 9)
        @(posedge aclk);
        sleep <= 1'b1;
        @(negedge aclk);
        @(negedge aclk);
        v = channel_pin;
        n = 0;
        repeat (40) begin @(negedge aclk); if (channel_pin !== v) n++; end
        `CHK(timer16_hold, 1'b1)
        `CHK(n, 0)
        @(posedge aclk);
        sleep <= 1'b0;
        wr(`CCPU_OFF_VHI, 8'h00);
        wr(`CCPU_OFF_VLO, 8'h00);
        repeat (20) @(posedge aclk);
        n = 0;
        repeat (40) begin @(negedge aclk); if (channel_pin !== 1'b0) n++; end
        `CHK(n, 0)
        $display("test pwm done");
        wr(`CCPU_OFF_CTRL, 8'h00);
        wr(`CCPU_OFF_STAT, 8'h01);
        wr(`CCPU_OFF_CFG, 8'h03);
        wr(`CCPU_OFF_CTRL, 8'h83);
        sleep <= 1'b1;
        cap <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(`CCPU_OFF_STAT); `CHK(q[0], 1'b0)
        ext <= 1'b1;
        cap <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(`CCPU_OFF_STAT); `CHK(q[0], 1'b1)
        `CHK(wake_n, 1)
        sleep <= 1'b0;
        $display("test capture done");
        wrap_up();
    end
endmodule
`default_nettype wire
